// ### include/hpctl_pkg.sv
package hpctl_pkg;

    // ------------------------------------------------------------
    // APB register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] HPCTL_CTRL_OFS = 8'h00;
    localparam logic [7:0] HPCTL_STAT_OFS = 8'h04;
    localparam logic [7:0] HPCTL_IRQ_STAT_OFS = 8'h08;
    localparam logic [7:0] HPCTL_IRQ_MASK_OFS = 8'h0C;
    localparam logic [7:0] HPCTL_CORE_STAT_OFS = 8'h10;
    localparam logic [7:0] HPCTL_HIGH_OFS = 8'h14;
    localparam logic [7:0] HPCTL_MID_OFS = 8'h18;
    localparam logic [7:0] HPCTL_LOW_OFS = 8'h1C;

    // ------------------------------------------------------------
    // Host-side addresses of the three data byte registers
    // ------------------------------------------------------------
    localparam logic [2:0] HPCTL_HADDR_FIRST = 3'h5;
    localparam logic [2:0] HPCTL_HADDR_MID = 3'h6;
    localparam logic [2:0] HPCTL_HADDR_LAST = 3'h7;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int HPCTL_RECEIVE_REQUEST_ENABLE_BIT = 0;
    localparam int HPCTL_TRANSMIT_REQUEST_ENABLE_BIT = 1;
    localparam int HPCTL_DREQ_BIT = 2;
    localparam int HPCTL_HF0_BIT = 3;
    localparam int HPCTL_HF1_BIT = 4;
    localparam int HPCTL_LEND_BIT = 5;
    localparam logic [7:0] HPCTL_CTRL_WMASK = 8'h3F;
    localparam logic [7:0] HPCTL_CTRL_RESET = 8'h00;

    // Interrupt status bits
    localparam int HPCTL_IRQ_TX_BIT = 0;
    localparam int HPCTL_IRQ_RX_BIT = 1;
    localparam logic [1:0] HPCTL_IRQ_RESET = 2'h0;

    typedef enum logic [1:0] {
        HPCTL_SEL_NONE = 2'b00,
        HPCTL_SEL_HIGH = 2'b01,
        HPCTL_SEL_MID = 2'b10,
        HPCTL_SEL_LOW = 2'b11
    } hpctl_sel_type;

endpackage : hpctl_pkg

// ### design/hpctl_top.sv
`timescale 1ns/1ns

// Overview of operation
// [R1] Endian bit clear: high byte at host address 5, middle 6, low 7.
// [R2] Endian bit set: high byte at host address 7, middle 6, low 5.
// [R3] Host flag one, control bit 4, host-written only, shown to core.
// [R4] Host flag zero, control bit 3, host-written only, shown to core.
// [R5] Double-request clear: shared pins are single request out, ack in.
// [R6] Double-request set: shared pins are transmit and receive requests.
// [R7] Transmit request raised only when its enable and transmit-empty set.
// [R8] Receive request raised only when its enable and receive-full set.
// [R9] Single mode request pin is OR of both enabled conditions.
// [R10] Double mode each pin follows only its own enabled condition.
// [R11] Control register host readable and writable; core cannot reach it.
// [R12] Hardware and software reset clear the whole control register.
// [R13] Reserved control bit 6 held at zero and reads zero.
module hpctl_top
    import hpctl_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic soft_reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic transmit_empty_status,
    input wire logic receive_full_status,
    input wire logic host_acknowledge_pin,
    input wire logic [2:0] host_addr,
    output logic [1:0] host_byte_sel,
    output logic shared_host_request_pin,
    output logic receive_request_pin,
    output logic host_ack_seen,
    output logic host_to_core_flag_one,
    output logic host_to_core_flag_zero,
    output logic irq
);

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    logic [1:0] irq_stat_q;
    logic [1:0] irq_stat_d;
    logic [1:0] irq_mask_q;
    logic [1:0] irq_mask_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic pslverr_q;
    logic pslverr_d;
    logic [1:0] sel_q;
    logic [1:0] sel_d;
    logic ack_q;
    logic ack_d;
    // Registered copies of the request pins for the status register
    logic tx_req_q;
    logic rx_req_q;
    logic share_q;
    logic rxpin_q;
    logic tx_req_d;
    logic rx_req_d;
    logic share_d;
    logic rxpin_d;
    logic tx_prev_q;
    logic rx_prev_q;
    logic tx_prev_d;
    logic rx_prev_d;
    // One wait state: set in the first access cycle, cleared in the second
    logic wait_q;
    logic wait_d;

    // Decoded bus strobes and control fields
    logic access;
    logic wr;
    logic little_endian_select;
    logic double_request_select;
    logic transmit_request_enable;
    logic receive_request_enable;
    logic [7:0] core_status;
    logic [1:0] irq_event;
    hpctl_sel_type sel_c;

    assign access = psel & penable;
    // Writes land only at the edge that completes the access, so a
    // write-one-to-clear acts once; an event raised in the first access cycle is still cleared
    assign wr = access & pwrite & wait_q;
    assign little_endian_select = ctrl_q[HPCTL_LEND_BIT];
    assign double_request_select = ctrl_q[HPCTL_DREQ_BIT];
    assign transmit_request_enable = ctrl_q[HPCTL_TRANSMIT_REQUEST_ENABLE_BIT];
    assign receive_request_enable = ctrl_q[HPCTL_RECEIVE_REQUEST_ENABLE_BIT];

    // Core sees the flags read-only; no core port can write them.
    assign core_status = {6'h00, ctrl_q[HPCTL_HF1_BIT],
                          ctrl_q[HPCTL_HF0_BIT]};

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    always_comb begin
        ctrl_d = ctrl_q;
        // Software reset shares this clear path; it reaches no other state
        if (rst || soft_reset) begin
            ctrl_d = HPCTL_CTRL_RESET; // [R12]
        end else if (wr && paddr == HPCTL_CTRL_OFS) begin
            // Bit 6 and the initialize bit are never stored
            ctrl_d = pwdata[7:0] & HPCTL_CTRL_WMASK; // [R11] [R13]
        end
    end

    always_ff @(posedge clk) begin
        ctrl_q <= ctrl_d;
    end

    // ------------------------------------------------------------
    // Request pins
    // ------------------------------------------------------------
    // Pins are registered so an enable change never glitches the host line
    always_comb begin
        tx_req_d = transmit_request_enable & transmit_empty_status; // [R7]
        rx_req_d = receive_request_enable & receive_full_status; // [R8]
        if (double_request_select) begin
            share_d = tx_req_d; // [R6] [R10]
            rxpin_d = rx_req_d; // [R10]
        end else begin
            share_d = tx_req_d | rx_req_d; // [R5] [R9]
            rxpin_d = 1'b0;
        end
        if (rst) begin
            tx_req_d = 1'b0;
            rx_req_d = 1'b0;
            share_d = 1'b0;
            rxpin_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        tx_req_q <= tx_req_d;
        rx_req_q <= rx_req_d;
        share_q <= share_d;
        rxpin_q <= rxpin_d;
    end

    // In single mode the second shared pin is the acknowledge input
    // In double mode that pin is the receive request, so the copy reads 0
    always_comb begin
        ack_d = double_request_select ? 1'b0 : host_acknowledge_pin; // [R5]
        if (rst) begin
            ack_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        ack_q <= ack_d;
    end

    // ------------------------------------------------------------
    // Host byte address decode
    // ------------------------------------------------------------
    always_comb begin
        sel_c = HPCTL_SEL_NONE;
        // Addresses outside the data bytes select nothing
        case (host_addr)
            HPCTL_HADDR_FIRST: begin
                sel_c = little_endian_select ? HPCTL_SEL_LOW
                                             : HPCTL_SEL_HIGH; // [R1] [R2]
            end
            HPCTL_HADDR_MID: begin
                sel_c = HPCTL_SEL_MID; // [R1] [R2]
            end
            HPCTL_HADDR_LAST: begin
                sel_c = little_endian_select ? HPCTL_SEL_HIGH
                                             : HPCTL_SEL_LOW; // [R1] [R2]
            end
            default: begin
                sel_c = HPCTL_SEL_NONE;
            end
        endcase
        sel_d = rst ? 2'h0 : sel_c;
    end

    always_ff @(posedge clk) begin
        sel_q <= sel_d;
    end

    // ------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------
    // Rising edges of the enabled requests are the events
    assign irq_event = {rx_req_q & ~rx_prev_q, tx_req_q & ~tx_prev_q};

    always_comb begin
        irq_stat_d = irq_stat_q;
        irq_mask_d = irq_mask_q;
        if (wr && paddr == HPCTL_IRQ_STAT_OFS) begin
            irq_stat_d = irq_stat_q & ~pwdata[1:0];
        end
        if (wr && paddr == HPCTL_IRQ_MASK_OFS) begin
            irq_mask_d = pwdata[1:0];
        end
        // A new event beats a clear in the same cycle
        irq_stat_d = irq_stat_d | irq_event;
        tx_prev_d = tx_req_q;
        rx_prev_d = rx_req_q;
        if (rst) begin
            irq_stat_d = HPCTL_IRQ_RESET;
            irq_mask_d = HPCTL_IRQ_RESET;
            tx_prev_d = 1'b0;
            rx_prev_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        irq_stat_q <= irq_stat_d;
        irq_mask_q <= irq_mask_d;
        tx_prev_q <= tx_prev_d;
        rx_prev_q <= rx_prev_d;
    end

    // ------------------------------------------------------------
    // APB read path
    // ------------------------------------------------------------
    always_comb begin
        // Read data is held between reads so a slow master sees it stand
        prdata_d = prdata_q;
        pslverr_d = 1'b0;
        if (access && !pwrite) begin
            case (paddr)
                HPCTL_CTRL_OFS: prdata_d = {24'h000000, ctrl_q}; // [R11]
                HPCTL_STAT_OFS: prdata_d = {26'h0000000, ack_q,
                    rx_req_q, tx_req_q, receive_full_status,
                    transmit_empty_status, double_request_select};
                HPCTL_IRQ_STAT_OFS: prdata_d = {30'h00000000, irq_stat_q};
                HPCTL_IRQ_MASK_OFS: prdata_d = {30'h00000000, irq_mask_q};
                HPCTL_CORE_STAT_OFS: prdata_d = {24'h000000, core_status};
                HPCTL_HIGH_OFS: prdata_d = {29'h00000000,
                    little_endian_select ? HPCTL_HADDR_LAST
                                         : HPCTL_HADDR_FIRST};
                HPCTL_MID_OFS: prdata_d = {29'h00000000, HPCTL_HADDR_MID};
                HPCTL_LOW_OFS: prdata_d = {29'h00000000,
                    little_endian_select ? HPCTL_HADDR_FIRST
                                         : HPCTL_HADDR_LAST};
                default: begin
                    prdata_d = 32'h00000000;
                    pslverr_d = 1'b1;
                end
            endcase
        end else if (access) begin
            // Writes to read-only offsets are refused rather than dropped
            pslverr_d = !(paddr == HPCTL_CTRL_OFS
                || paddr == HPCTL_IRQ_STAT_OFS
                || paddr == HPCTL_IRQ_MASK_OFS);
        end
        if (rst) begin
            prdata_d = 32'h00000000;
            pslverr_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        prdata_q <= prdata_d;
        pslverr_q <= pslverr_d;
    end

    // ------------------------------------------------------------
    // APB handshake
    // ------------------------------------------------------------
    // Data is registered, so the access phase takes two cycles
    always_comb begin
        wait_d = 1'b0;
        if (!rst && access) begin
            // The second access cycle clears it for the release
            wait_d = !wait_q;
        end
    end

    always_ff @(posedge clk) begin
        wait_q <= wait_d;
    end

    assign pready = wait_q;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q & wait_q;

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign shared_host_request_pin = share_q;
    assign receive_request_pin = rxpin_q;
    assign host_ack_seen = ack_q;
    assign host_byte_sel = sel_q;
    assign host_to_core_flag_one = ctrl_q[HPCTL_HF1_BIT]; // [R3]
    assign host_to_core_flag_zero = ctrl_q[HPCTL_HF0_BIT]; // [R4]
    // Level output: stays high until software clears or masks the bit
    assign irq = |(irq_stat_q & irq_mask_q);

endmodule : hpctl_top

// ### tb/hpctl_properties.sv
`timescale 1ns/1ns
module hpctl_properties
    import hpctl_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic soft_reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic transmit_empty_status,
    input wire logic receive_full_status,
    input wire logic host_acknowledge_pin,
    input wire logic [2:0] host_addr,
    input wire logic [1:0] host_byte_sel,
    input wire logic shared_host_request_pin,
    input wire logic receive_request_pin,
    input wire logic host_ack_seen,
    input wire logic host_to_core_flag_one,
    input wire logic host_to_core_flag_zero
);
    logic [5:0] ctl_q;
    logic [5:0] ctl_d;
    logic [1:0] sel_exp;
    logic tx;
    logic rx;
    logic bus_write;
    assign tx = transmit_empty_status;
    assign rx = receive_full_status;
    assign bus_write = psel && penable && pready && pwrite;
    // ----
    // Shadow of the control register, kept from APB writes
    // ----
    always_comb begin
        ctl_d = ctl_q;
        if (bus_write && paddr == HPCTL_CTRL_OFS) begin
            ctl_d = pwdata[5:0];
        end
        if (rst || soft_reset) begin
            ctl_d = 6'h00;
        end
    end
    always_ff @(posedge clk) begin
        ctl_q <= ctl_d;
    end
    always_comb begin
        sel_exp = HPCTL_SEL_NONE;
        case (host_addr)
            HPCTL_HADDR_FIRST: begin
                sel_exp = ctl_q[5] ? HPCTL_SEL_LOW : HPCTL_SEL_HIGH;
            end
            HPCTL_HADDR_MID: begin
                sel_exp = HPCTL_SEL_MID;
            end
            HPCTL_HADDR_LAST: begin
                sel_exp = ctl_q[5] ? HPCTL_SEL_HIGH : HPCTL_SEL_LOW;
            end
            default: begin
                sel_exp = HPCTL_SEL_NONE;
            end
        endcase
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    flag_one_a: assert property (host_to_core_flag_one == ctl_q[4])
        else $error("flag one differs from control");
    flag_zero_a: assert property (host_to_core_flag_zero == ctl_q[3])
        else $error("flag zero differs from control");
    single_req_a: assert property ($past(!ctl_q[2]) |->
        shared_host_request_pin == $past(ctl_q[1] && tx || ctl_q[0] && rx))
        else $error("single request pin wrong");
    tx_req_a: assert property ($past(ctl_q[2]) |->
        shared_host_request_pin == $past(ctl_q[1] && tx))
        else $error("transmit request pin wrong");
    rx_req_a: assert property (receive_request_pin ==
        $past(ctl_q[2] && ctl_q[0] && rx)) else $error("receive pin wrong");
    ack_seen_a: assert property (host_ack_seen ==
        $past(!ctl_q[2] && host_acknowledge_pin))
        else $error("ack copy wrong");
    byte_sel_a: assert property (host_byte_sel == $past(sel_exp))
        else $error("byte select wrong");
    ctl_read_a: assert property (psel && pready && !pwrite &&
        paddr == HPCTL_CTRL_OFS |-> prdata == {26'h0, ctl_q})
        else $error("control read wrong");
    soft_clear_a: assert property (soft_reset |=>
        !host_to_core_flag_one && !host_to_core_flag_zero)
        else $error("soft reset left a flag");
endmodule : hpctl_properties
bind hpctl_top hpctl_properties i_hpctl_properties (.*);

// ### tb/hpctl_host_model.sv
`timescale 1ns/1ns
module hpctl_host_model(
    input wire logic clk,
    input wire logic rst,
    input wire logic [2:0] pick_addr,
    input wire logic req,
    input wire logic slow,
    output logic [2:0] host_addr,
    output logic ack
);
    logic [1:0] seen_q;
    // Cleared with the block so the acknowledge never starts unknown
    always_ff @(posedge clk) begin
        if (rst) begin
            seen_q <= 2'h0;
        end else begin
            seen_q <= {seen_q[0], req};
        end
    end
    // Host answers a request after one or two cycles
    assign ack = slow ? seen_q[1] : seen_q[0];
    assign host_addr = pick_addr;
endmodule : hpctl_host_model

// ### tb/test_host_port_request_endian_control.sv
`timescale 1ns/1ns
module test_host_port_request_endian_control
    import hpctl_pkg::*;
;
    logic clk, rst, soft_reset, psel, penable, pwrite, tx, rx, slow, err;
    logic pready, pslverr, sh_req, rx_req, ack, ack_seen, flag1, flag0, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] pick, haddr;
    logic [1:0] sel;
    int miscompares = 0;
    int tests_run = 0;
    int cycles = 0;
    hpctl_top i_hpctl_top (.clk(clk), .rst(rst), .soft_reset(soft_reset),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .transmit_empty_status(tx), .receive_full_status(rx),
        .host_acknowledge_pin(ack), .host_addr(haddr), .host_byte_sel(sel),
        .shared_host_request_pin(sh_req), .receive_request_pin(rx_req),
        .host_ack_seen(ack_seen), .host_to_core_flag_one(flag1),
        .host_to_core_flag_zero(flag0), .irq(irq));
    hpctl_host_model i_hpctl_host_model (.clk(clk), .rst(rst),
        .pick_addr(pick), .req(sh_req), .slow(slow), .host_addr(haddr),
        .ack(ack));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            conclude();
        end
    end
    task conclude;
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : conclude
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask : chk
    // ----
    // APB master: holds the request until pready is sampled high
    // ----
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task t_regs;
        apb(0, HPCTL_CTRL_OFS, 0);
        chk("ctrl reset", 32'h0, rd);
        apb(1, HPCTL_CTRL_OFS, 32'hFF);
        chk("ctrl write error", 32'h0, {31'h0, err});
        apb(0, HPCTL_CTRL_OFS, 0);
        chk("ctrl", 32'h3F, rd);
        apb(1, HPCTL_CORE_STAT_OFS, 0);
        chk("core write refused", 32'h1, {31'h0, err});
        apb(0, HPCTL_CORE_STAT_OFS, 0);
        chk("core view", 32'h3, rd);
        chk("flags", 32'h3, {30'h0, flag1, flag0});
        apb(0, 8'h20, 0);
        chk("unmapped", 32'h1, {31'h0, err});
        soft_reset <= 1'b1;
        @(posedge clk);
        soft_reset <= 1'b0;
        apb(0, HPCTL_CTRL_OFS, 0);
        chk("soft reset", 32'h0, rd);
        chk("flags cleared", 32'h0, {30'h0, flag1, flag0});
    endtask : t_regs
    task t_endian;
        logic [1:0] sel_exp;
        for (int l = 0; l < 2; l++) begin
            apb(1, HPCTL_CTRL_OFS, l << 5);
            apb(0, HPCTL_HIGH_OFS, 0);
            chk("high byte addr", l ? 32'h7 : 32'h5, rd);
            for (int a = 5; a < 8; a++) begin
                pick <= a[2:0];
                repeat (3) @(posedge clk);
                if (a == 6) begin
                    sel_exp = HPCTL_SEL_MID;
                end else if ((a == 5) != (l == 1)) begin
                    sel_exp = HPCTL_SEL_HIGH;
                end else begin
                    sel_exp = HPCTL_SEL_LOW;
                end
                chk("byte sel", 32'(sel_exp), 32'(sel));
            end
        end
    endtask : t_endian
    task t_req;
        logic req_exp;
        for (int m = 0; m < 32; m++) begin
            apb(1, HPCTL_CTRL_OFS, m >> 2);
            tx <= m[1];
            rx <= m[0];
            repeat (3) @(posedge clk);
            req_exp = m[4] ? m[3] & m[1] : m[3] & m[1] | m[2] & m[0];
            chk("req pin", 32'(req_exp), 32'(sh_req));
            chk("rx pin", 32'(m[4] & m[2] & m[0]), 32'(rx_req));
            // The host answers one or two cycles later, then the copy
            repeat (2) @(posedge clk);
            chk("ack seen", 32'(!m[4] && req_exp), 32'(ack_seen));
        end
    endtask : t_req
    task t_irq;
        tx <= 1'b0;
        apb(1, HPCTL_CTRL_OFS, 32'h2);
        apb(1, HPCTL_IRQ_STAT_OFS, 32'h3);
        apb(1, HPCTL_IRQ_MASK_OFS, 32'h1);
        tx <= 1'b1;
        repeat (3) @(posedge clk);
        chk("irq raised", 32'h1, {31'h0, irq});
        apb(0, HPCTL_IRQ_STAT_OFS, 0);
        chk("irq status", 32'h1, rd);
        apb(1, HPCTL_IRQ_MASK_OFS, 32'h0);
        @(posedge clk);
        chk("irq masked", 32'h0, {31'h0, irq});
        apb(1, HPCTL_IRQ_MASK_OFS, 32'h1);
        apb(1, HPCTL_IRQ_STAT_OFS, 32'h1);
        @(posedge clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
    endtask : t_irq
    initial begin
        rst = 1'b1;
        soft_reset = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        tx = 1'b0;
        rx = 1'b0;
        pick = 3'h0;
        slow = 1'b0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_endian();
        t_req();
        slow <= 1'b1;
        t_req();
        t_irq();
        conclude();
    end
endmodule : test_host_port_request_endian_control
